// file: logic/sgs_params.svh
`ifndef SGS_PARAMS_SVH
`define SGS_PARAMS_SVH

// ================================================================
// Register port
`define SGS_ADDR_W          4
`define SGS_DATA_W          32
`define SGS_REG_CTRL        4'h0
`define SGS_REG_USED        4'h1
`define SGS_REG_FORCE       4'h2
`define SGS_REG_REMOTE      4'h3
`define SGS_REG_STATUS      4'h4

// ================================================================
// Field positions and reset values
`define SGS_CTRL_OVR_BIT    0
`define SGS_USED_MSB        2
`define SGS_USED_MAX        3'h6
`define SGS_USED_RST        3'h0
`define SGS_SEL_MSB         3
`define SGS_SEL_NONE        4'h0
`define SGS_ST_GRP_MSB      3
`define SGS_ST_REM_FAIL     4
`define SGS_ST_FRC_FAIL     5
`define SGS_ST_CFG_FAIL     6
`define SGS_ST_OVR          7
`define SGS_GRP_RST         3'h0

// ================================================================
// Processing cycle timing
`define SGS_CLK_PERIOD_NS   5
`define SGS_PROC_PERIOD_NS  1000

`endif

// file: logic/sgs_pkg.sv
package sgs_pkg;

    // ================================================================
    // Sampled request inputs, one bit per group.
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] rise;
    } sgs_req_t;

    // ================================================================
    // Selector modes.
    typedef enum logic [2:0] {
        SGS_ST_IDLE  = 3'b001,
        SGS_ST_AUTO  = 3'b010,
        SGS_ST_FORCE = 3'b100
    } sgs_state_t;

endpackage

// file: logic/sgs_req_sampler.sv
module sgs_req_sampler
    import sgs_pkg::*;
#(
    parameter int N = 8
) (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          tick_i,
    input  wire logic [N-1:0]  req_pin_i,
    output sgs_req_t           req_o
);

    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] level_ff;
    logic [N-1:0] rise_ff;

    // ================================================================
    // Pin synchroniser and per-cycle sampling.
    // The edge is judged against the previous processing-cycle sample,
    // so a pulse shorter than one processing cycle can be missed.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    meta_ff[g]  <= 1'b0;
                    sync_ff[g]  <= 1'b0;
                    level_ff[g] <= 1'b0;
                    rise_ff[g]  <= 1'b0;
                end else begin
                    meta_ff[g] <= req_pin_i[g];
                    sync_ff[g] <= meta_ff[g];
                    if (tick_i) begin
                        level_ff[g] <= sync_ff[g];
                        rise_ff[g]  <= sync_ff[g] & ~level_ff[g];
                    end
                end
            end
        end
    endgenerate

    assign req_o.level = level_ff;
    assign req_o.rise  = rise_ff;

endmodule

// file: logic/sgs_selector.sv
// Our own choices: strobed register access and the register offsets.
`include "sgs_params.svh"

module sgs_selector
    import sgs_pkg::*;
#(
    parameter int N        = 8,
    parameter int PROC_CYC = `SGS_PROC_PERIOD_NS / `SGS_CLK_PERIOD_NS
) (
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [N-1:0]           group_request_i,
    input  wire logic [`SGS_ADDR_W-1:0] addr_i,
    input  wire logic [`SGS_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic [`SGS_DATA_W-1:0]      rdata_o,
    output logic [3:0]                  active_group_o,
    output logic [N-1:0]                active_onehot_o,
    output logic                        override_enable_o
);

    localparam int IW = $clog2(N);
    localparam int CW = $clog2(PROC_CYC + 1);

    // ================================================================
    // Shared decoders

    // Lowest index set wins, which is the highest priority group.
    function automatic logic [IW:0] first_set(input logic [N-1:0] v);
        logic [IW:0] res;
        res = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                res = {1'b1, IW'(i)};
            end
        end
        return res;
    endfunction

    // Groups from one down to the given index, inclusive.
    function automatic logic [N-1:0] upto(input logic [IW-1:0] idx);
        logic [N-1:0] m;
        m = '0;
        for (int i = 0; i < N; i++) begin
            m[i] = (IW'(i) <= idx);
        end
        return m;
    endfunction

    // Selection code: zero is none, one to N name a group.
    function automatic logic [N-1:0] dec_sel(input logic [`SGS_SEL_MSB:0] sel);
        logic [N-1:0] m;
        m = '0;
        for (int i = 0; i < N; i++) begin
            m[i] = (sel == 4'(i + 1));
        end
        return m;
    endfunction

    // ================================================================
    // Processing cycle divider

    logic [CW-1:0] div_ff;
    logic          tick_ff;
    logic          eval_ff;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == CW'(PROC_CYC - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + CW'(1);
            tick_ff <= 1'b0;
        end
    end

    // Evaluation runs one cycle after sampling so it sees fresh samples.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eval_ff <= 1'b0;
        end else begin
            eval_ff <= tick_ff;
        end
    end

    // ================================================================
    // Request inputs

    sgs_req_t req;

    sgs_req_sampler #(
        .N         (N)
    ) u_sampler (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick_ff),
        .req_pin_i (group_request_i),
        .req_o     (req)
    );

    // ================================================================
    // Settings

    logic                 ovr_ff;
    logic [`SGS_USED_MSB:0] used_ff;
    logic [`SGS_SEL_MSB:0]  frc_sel_ff;
    logic                 frc_pend_ff;
    logic [`SGS_SEL_MSB:0]  rem_sel_ff;
    logic                 rem_pend_ff;
    logic                 rem_fail_ff;
    logic                 frc_fail_ff;
    logic                 cfg_fail_ff;

    logic wr_ctrl;
    logic wr_used;
    logic wr_frc;
    logic wr_rem;
    logic wr_stat;

    assign wr_ctrl = wr_i && (addr_i == `SGS_REG_CTRL);
    assign wr_used = wr_i && (addr_i == `SGS_REG_USED);
    assign wr_frc  = wr_i && (addr_i == `SGS_REG_FORCE);
    assign wr_rem  = wr_i && (addr_i == `SGS_REG_REMOTE);
    assign wr_stat = wr_i && (addr_i == `SGS_REG_STATUS);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ovr_ff <= 1'b0;
        end else if (wr_ctrl) begin
            ovr_ff <= wdata_i[`SGS_CTRL_OVR_BIT];
        end
    end

    // Larger codes saturate so the setting never names a missing choice.
    // Newly enabled groups carry no state here, so they start clean.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            used_ff <= `SGS_USED_RST;
        end else if (wr_used) begin
            if (wdata_i[`SGS_USED_MSB:0] > `SGS_USED_MAX) begin
                used_ff <= `SGS_USED_MAX;
            end else begin
                used_ff <= wdata_i[`SGS_USED_MSB:0];
            end
        end
    end

    // A forced selection is only a one-shot request; a write with the
    // override off is dropped and flagged.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            frc_sel_ff  <= `SGS_SEL_NONE;
            frc_pend_ff <= 1'b0;
        end else if (wr_frc) begin
            frc_sel_ff  <= wdata_i[`SGS_SEL_MSB:0];
            frc_pend_ff <= ovr_ff && (wdata_i[`SGS_SEL_MSB:0] != `SGS_SEL_NONE);
        end else if (eval_ff) begin
            frc_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rem_sel_ff  <= `SGS_SEL_NONE;
            rem_pend_ff <= 1'b0;
        end else if (wr_rem) begin
            rem_sel_ff  <= wdata_i[`SGS_SEL_MSB:0];
            rem_pend_ff <= (wdata_i[`SGS_SEL_MSB:0] != `SGS_SEL_NONE);
        end else if (eval_ff) begin
            rem_sel_ff  <= `SGS_SEL_NONE;
            rem_pend_ff <= 1'b0;
        end
    end

    // ================================================================
    // Arbitration

    sgs_state_t     state_ff;
    sgs_state_t     nxt_state;
    logic [IW-1:0]  active_ff;
    logic [IW-1:0]  nxt_active;
    logic           rem_refuse;
    logic           cfg_refuse;
    logic           frc_refuse;

    logic [N-1:0]   en;
    logic [N-1:0]   lvl;
    logic [IW:0]    h_res;
    logic           have_h;
    logic [IW-1:0]  h;
    logic [N-1:0]   allow;
    logic [N-1:0]   rem_vec;
    logic [N-1:0]   frc_vec;
    logic [N-1:0]   auto_vec;
    logic [IW:0]    c_res;
    logic [IW:0]    f_res;

    assign frc_refuse = wr_frc && !ovr_ff
                        && (wdata_i[`SGS_SEL_MSB:0] != `SGS_SEL_NONE);

    always_comb begin
        en       = upto(IW'(used_ff));
        lvl      = req.level & en;
        h_res    = first_set(lvl);
        have_h   = h_res[IW];
        h        = h_res[IW-1:0];
        // The highest held level masks everything below it; group seven
        // is the lowest that can be enabled, so its mask covers all enabled groups.
        allow    = have_h ? upto(h) : '1;
        rem_vec  = rem_pend_ff ? dec_sel(rem_sel_ff) : '0;
        frc_vec  = frc_pend_ff ? dec_sel(frc_sel_ff) : '0;
        auto_vec = (req.rise | rem_vec) & en & allow;
        c_res    = first_set(auto_vec);
        f_res    = first_set(frc_vec & en);

        nxt_state  = state_ff;
        nxt_active = active_ff;
        rem_refuse = 1'b0;
        cfg_refuse = 1'b0;

        if (eval_ff) begin
            case (state_ff)
                SGS_ST_IDLE: begin
                    nxt_active = `SGS_GRP_RST;
                    cfg_refuse = |((req.rise | rem_vec) & ~en);
                    if (ovr_ff) begin
                        nxt_state = SGS_ST_FORCE;
                    end else if (used_ff != `SGS_USED_RST) begin
                        nxt_state = SGS_ST_AUTO;
                    end
                end
                SGS_ST_AUTO: begin
                    cfg_refuse = |((req.rise | rem_vec) & ~en);
                    rem_refuse = |(rem_vec & en & ~allow);
                    if (ovr_ff) begin
                        nxt_state = SGS_ST_FORCE;
                    end else if (used_ff == `SGS_USED_RST) begin
                        nxt_state  = SGS_ST_IDLE;
                        nxt_active = `SGS_GRP_RST;
                    end else if (c_res[IW]) begin
                        nxt_active = c_res[IW-1:0];
                    end else if (have_h && (h < active_ff)) begin
                        nxt_active = h;
                    end else if (!en[active_ff]) begin
                        nxt_active = `SGS_GRP_RST;
                    end
                end
                SGS_ST_FORCE: begin
                    // Automatic requests are ignored; remote ones are refused.
                    rem_refuse = |rem_vec;
                    cfg_refuse = |(frc_vec & ~en);
                    if (f_res[IW]) begin
                        nxt_active = f_res[IW-1:0];
                    end
                    if (!ovr_ff) begin
                        if (have_h) begin
                            nxt_active = h;
                        end
                        // Without a held level the forced group stays on the way back to AUTO.
                        if (used_ff == `SGS_USED_RST) begin
                            nxt_state  = SGS_ST_IDLE;
                            nxt_active = `SGS_GRP_RST;
                        end else begin
                            nxt_state = SGS_ST_AUTO;
                        end
                    end
                end
                default: begin
                    nxt_state  = SGS_ST_IDLE;
                    nxt_active = `SGS_GRP_RST;
                end
            endcase
        end
    end

    // This state belongs to the selector alone and is shared with no
    // other group selection logic.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff  <= SGS_ST_IDLE;
            active_ff <= `SGS_GRP_RST;
        end else begin
            state_ff  <= nxt_state;
            active_ff <= nxt_active;
        end
    end

    // ================================================================
    // Sticky refusal flags; a new refusal beats a clear in the same cycle.

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rem_fail_ff <= 1'b0;
            frc_fail_ff <= 1'b0;
            cfg_fail_ff <= 1'b0;
        end else begin
            rem_fail_ff <= rem_refuse
                           | (rem_fail_ff & ~(wr_stat & wdata_i[`SGS_ST_REM_FAIL]));
            frc_fail_ff <= frc_refuse
                           | (frc_fail_ff & ~(wr_stat & wdata_i[`SGS_ST_FRC_FAIL]));
            cfg_fail_ff <= cfg_refuse
                           | (cfg_fail_ff & ~(wr_stat & wdata_i[`SGS_ST_CFG_FAIL]));
        end
    end

    // ================================================================
    // Read port and outputs

    logic [`SGS_DATA_W-1:0] rdata_ff;
    logic [`SGS_DATA_W-1:0] nxt_rdata;
    logic [3:0]             grp_ff;
    logic [N-1:0]           oh_ff;
    logic                   ovr_out_ff;

    always_comb begin
        nxt_rdata = '0;
        if (rd_i) begin
            case (addr_i)
                `SGS_REG_CTRL: begin
                    nxt_rdata[`SGS_CTRL_OVR_BIT] = ovr_ff;
                end
                `SGS_REG_USED: begin
                    nxt_rdata[`SGS_USED_MSB:0] = used_ff;
                end
                `SGS_REG_FORCE: begin
                    nxt_rdata[`SGS_SEL_MSB:0] = frc_sel_ff;
                end
                `SGS_REG_REMOTE: begin
                    nxt_rdata[`SGS_SEL_MSB:0] = rem_sel_ff;
                end
                `SGS_REG_STATUS: begin
                    nxt_rdata[`SGS_ST_GRP_MSB:0] = 4'(active_ff) + 4'h1;
                    nxt_rdata[`SGS_ST_REM_FAIL]  = rem_fail_ff;
                    nxt_rdata[`SGS_ST_FRC_FAIL]  = frc_fail_ff;
                    nxt_rdata[`SGS_ST_CFG_FAIL]  = cfg_fail_ff;
                    nxt_rdata[`SGS_ST_OVR]       = ovr_ff;
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs trail the active group by one cycle so they stay registered.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            grp_ff     <= 4'h1;
            oh_ff      <= N'(1);
            ovr_out_ff <= 1'b0;
        end else begin
            grp_ff     <= 4'(active_ff) + 4'h1;
            oh_ff      <= N'(1) << active_ff;
            ovr_out_ff <= ovr_ff;
        end
    end

    assign rdata_o           = rdata_ff;
    assign active_group_o    = grp_ff;
    assign active_onehot_o   = oh_ff;
    assign override_enable_o = ovr_out_ff;

endmodule

// file: verif/sgs_selector_assertions.sv
`include "sgs_params.svh"

module sgs_selector_checker
    import sgs_pkg::*;
#(
    parameter int N        = 8,
    parameter int PROC_CYC = 4
) (
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    input wire logic [N-1:0]           group_request_i,
    input wire logic [`SGS_ADDR_W-1:0] addr_i,
    input wire logic [`SGS_DATA_W-1:0] wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [`SGS_DATA_W-1:0] rdata_o,
    input wire logic [3:0]             active_group_o,
    input wire logic [N-1:0]           active_onehot_o,
    input wire logic                   override_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ================================================================
    // Helper logic
    // The count allows for the pin synchroniser and a full processing cycle.
    localparam int LVL_LAT = PROC_CYC + 8;
    logic ctrl_wr;
    int   lvl_cnt_ff;
    assign ctrl_wr = wr_i && (addr_i == `SGS_REG_CTRL);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !group_request_i[0] || override_enable_o) begin
            lvl_cnt_ff <= 0;
        end else if (lvl_cnt_ff < LVL_LAT) begin
            lvl_cnt_ff <= lvl_cnt_ff + 1;
        end
    end

    // ================================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_onehot;
        active_onehot_o == (8'h01 << (active_group_o - 4'h1));
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("one-hot output disagrees with group number");
    property p_range;
        active_group_o >= 4'h1 && active_group_o <= 4'h7;
    endproperty
    a_range: assert property (p_range)
        else $error("active group outside the enabled range");
    property p_rst;
        $fell(sys_rst_i) |-> active_group_o == 4'h1 && active_onehot_o == 8'h01
            && !override_enable_o && rdata_o == '0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not at defaults after reset");
    property p_rd_quiet;
        !$past(rd_i) |-> rdata_o == '0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data present without a read");
    property p_rd_status;
        rd_i && addr_i == `SGS_REG_STATUS |=> rdata_o[31:8] == '0 &&
            (rdata_o[3:0] == active_group_o || rdata_o[3:0] == $past(active_group_o));
    endproperty
    a_rd_status: assert property (p_rd_status)
        else $error("status read does not show the active group");
    property p_rd_ctrl;
        rd_i && addr_i == `SGS_REG_CTRL |=> rdata_o[31:1] == '0;
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control read has unused bits set");
    property p_ovr_on;
        ctrl_wr && wdata_i[0] |-> ##[1:2] override_enable_o;
    endproperty
    a_ovr_on: assert property (p_ovr_on)
        else $error("override did not turn on");
    property p_ovr_off;
        ctrl_wr && !wdata_i[0] |-> ##[1:2] !override_enable_o;
    endproperty
    a_ovr_off: assert property (p_ovr_off)
        else $error("override did not turn off");
    property p_ovr_hold;
        $changed(override_enable_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("override changed without a control write");
    property p_lvl1;
        lvl_cnt_ff == LVL_LAT |-> active_group_o == 4'h1;
    endproperty
    a_lvl1: assert property (p_lvl1)
        else $error("held group one level did not win");
endmodule

bind sgs_selector sgs_selector_checker #(.N(N), .PROC_CYC(PROC_CYC)) sgs_selector_checker_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .group_request_i(group_request_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .active_group_o(active_group_o), .active_onehot_o(active_onehot_o),
    .override_enable_o(override_enable_o));

// file: verif/sgs_pin_model.sv
module sgs_pin_model #(
    parameter int PROC_CYC = 4
) (
    input  wire logic       clk_i,
    input  wire logic [7:0] level_i,
    input  wire logic [7:0] pulse_i,
    output logic      [7:0] group_request_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ================================================================
    // Relay inputs
    // Inputs rest low; a pulse spans two ticks so the sampler cannot miss it.
    localparam int PW = 2 * PROC_CYC + 4;
    int hold_cnt [8];
    initial group_request_o = 8'h00;
    always @(posedge clk_i) begin
        for (int b = 0; b < 8; b++) begin
            if (pulse_i[b]) begin
                hold_cnt[b] <= PW;
            end else if (hold_cnt[b] > 0) begin
                hold_cnt[b] <= hold_cnt[b] - 1;
            end
            group_request_o[b] <= level_i[b] | pulse_i[b] | (hold_cnt[b] > 1);
        end
    end
endmodule

// file: verif/sgs_selector_test.sv
`include "sgs_params.svh"

module sgs_selector_test;
    import sgs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PROC_CYC = 4;
    localparam int LAT      = PROC_CYC + 8;
    logic        clk_i, sys_rst_i, wr_i, rd_i, override_enable_o;
    logic [3:0]  addr_i, active_group_o;
    logic [7:0]  group_request_i, active_onehot_o;
    logic [7:0]  lvl_req, pls_req;
    logic [31:0] wdata_i, rdata_o, rv;
    int          n_mismatch, n_tests, cyc;

    sgs_pin_model #(.PROC_CYC(PROC_CYC)) sgs_pin_model_i (
        .clk_i(clk_i), .level_i(lvl_req), .pulse_i(pls_req), .group_request_o(group_request_i));
    sgs_selector #(.N(8), .PROC_CYC(PROC_CYC)) sgs_selector_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .group_request_i(group_request_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .active_group_o(active_group_o), .active_onehot_o(active_onehot_o),
        .override_enable_o(override_enable_o));

    // ================================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic settle;
        repeat (LAT) @(posedge clk_i);
    endtask
    // Flags are the expected status bits 7:4; bit 7 doubles as the override output.
    // Outputs are read a step after the edge so they are settled.
    task automatic grp(input logic [3:0] g, input logic [7:0] f);
        #1;
        chk("active_group_o", {28'h0, active_group_o}, {28'h0, g});
        chk("active_onehot_o", {24'h0, active_onehot_o}, {24'h0, 8'h01 << (g - 4'h1)});
        chk("override_enable_o", {31'h0, override_enable_o}, {31'h0, f[7]});
        rd(`SGS_REG_STATUS);
        chk("status", rv, {24'h0, f[7:4], g});
        wr(`SGS_REG_STATUS, 32'h70);
    endtask
    task automatic set_level(input int g, input logic v);
        @(posedge clk_i);
        lvl_req[g-1] <= v;
    endtask
    task automatic pulse(input int g);
        @(posedge clk_i);
        pls_req[g-1] <= 1'b1;
        @(posedge clk_i);
        pls_req[g-1] <= 1'b0;
        repeat (2 * PROC_CYC + 4) @(posedge clk_i);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ================================================================
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ================================================================
    // Sequence
    initial begin
        sys_rst_i = 1'b1;
        wr_i      = 1'b0;
        rd_i      = 1'b0;
        addr_i    = 4'h0;
        wdata_i   = 32'h0;
        lvl_req   = 8'h00;
        pls_req   = 8'h00;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        grp(4'h1, 8'h00);
        rd(`SGS_REG_CTRL);
        chk("ctrl", rv, 32'h0);
        rd(`SGS_REG_FORCE);
        chk("force", rv, 32'h0);
        rd(4'hf);
        chk("unmapped", rv, 32'h0);
        pulse(2);
        settle;
        grp(4'h1, 8'h40);
        wr(`SGS_REG_USED, 32'h7);
        rd(`SGS_REG_USED);
        chk("used", rv, 32'h6);
        pulse(3);
        settle;
        grp(4'h3, 8'h00);
        pulse(5);
        settle;
        grp(4'h5, 8'h00);
        set_level(4, 1'b1);
        settle;
        grp(4'h4, 8'h00);
        pulse(6);
        settle;
        grp(4'h4, 8'h00);
        set_level(3, 1'b1);
        settle;
        grp(4'h3, 8'h00);
        wr(`SGS_REG_REMOTE, 32'h5);
        settle;
        grp(4'h3, 8'h10);
        set_level(1, 1'b1);
        settle;
        grp(4'h1, 8'h00);
        pulse(2);
        settle;
        grp(4'h1, 8'h00);
        for (int g = 1; g < 5; g++) set_level(g, 1'b0);
        set_level(8, 1'b1);
        settle;
        grp(4'h1, 8'h40);
        pulse(2);
        settle;
        grp(4'h2, 8'h00);
        set_level(8, 1'b0);
        for (int g = 1; g < 9; g++) begin
            wr(`SGS_REG_REMOTE, 32'(g));
            settle;
            grp((g == 8) ? 4'h7 : 4'(g), (g == 8) ? 8'h40 : 8'h00);
        end
        wr(`SGS_REG_FORCE, 32'h2);
        settle;
        grp(4'h7, 8'h20);
        wr(`SGS_REG_CTRL, 32'h1);
        pulse(3);
        settle;
        grp(4'h7, 8'h80);
        wr(`SGS_REG_REMOTE, 32'h4);
        settle;
        grp(4'h7, 8'h90);
        for (int g = 8; g > 1; g--) begin
            wr(`SGS_REG_FORCE, 32'(g));
            settle;
            grp((g == 8) ? 4'h7 : 4'(g), (g == 8) ? 8'hc0 : 8'h80);
        end
        wr(`SGS_REG_CTRL, 32'h0);
        settle;
        grp(4'h2, 8'h00);
        wr(`SGS_REG_CTRL, 32'h1);
        set_level(4, 1'b1);
        settle;
        grp(4'h2, 8'h80);
        wr(`SGS_REG_CTRL, 32'h0);
        settle;
        grp(4'h4, 8'h00);
        set_level(4, 1'b0);
        wr(`SGS_REG_USED, 32'h0);
        settle;
        grp(4'h1, 8'h00);
        wr(`SGS_REG_CTRL, 32'h1);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        grp(4'h1, 8'h00);
        stop_test();
    end
endmodule
